// [gefl_edge_det.sv]
/*
  Pin synchroniser and edge detector, one lane per general pin.
  Assumes pins are asynchronous to clk_sys; emits one-cycle pulses.
*/
`timescale 1ns/100ps
module gefl_edge_det #(
  parameter int N = 8
) (
  input wire logic clk_sys,     // System clock
  input wire logic rst_n,       // Async reset, active low
  input wire logic [N-1:0] pinIn, // Raw general pins
  gefl_edge_if.src edges        // Edge pulses out
);

  logic [N-1:0] sync1_r, sync2_r, sync3_r, level_r;
  logic [N-1:0] level_nxt, rise_nxt, fall_nxt, rise_r, fall_r;
  logic [2:0] fill_r, fill_nxt;
  logic armed;

  // Edges are judged only once the chain holds real pin samples
  localparam logic [2:0] FILL_DONE = 3'(gefl_pkg::SYNC_STAGES + 1);
  assign armed = (fill_r == FILL_DONE);

  // A change counts only when stages two and three agree
  always_comb begin
    level_nxt = level_r;
    rise_nxt = '0;
    fall_nxt = '0;
    fill_nxt = fill_r;
    if (!armed) begin
      // Learn the settled level so a pin high at release is no edge
      fill_nxt = fill_r + 3'h1;
      level_nxt = sync3_r;
    end else begin
      for (int i = 0; i < N; i++) begin
        if ((sync2_r[i] == sync3_r[i]) && (sync3_r[i] != level_r[i])) begin
          level_nxt[i] = sync3_r[i];
          rise_nxt[i] = sync3_r[i];
          fall_nxt[i] = ~sync3_r[i];
        end
      end
    end
  end

  // Chain and level clear at reset; no edge is reported until armed
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      level_r <= '0;
      rise_r <= '0;
      fall_r <= '0;
      fill_r <= 3'h0;
    end else begin
      fill_r <= fill_nxt;
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      level_r <= level_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign edges.riseSeen = rise_r;
  assign edges.fallSeen = fall_r;

endmodule : gefl_edge_det

// [gefl_edge_if.sv]
/*
  Carrier between the pin edge detector and the flag logic.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/100ps
interface gefl_edge_if #(
  parameter int N = 8
);
  logic [N-1:0] riseSeen;
  logic [N-1:0] fallSeen;

  modport src (output riseSeen, output fallSeen);
  modport snk (input riseSeen, input fallSeen);
endinterface : gefl_edge_if

// [gefl_flags_asserts.sv]
/* Port checker for the edge flag block.
   Assumes it is bound to gefl_irq_flags, one clock domain. */
`timescale 1ns/100ps
module gefl_flags_asserts #(
  parameter int N = 8
) (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire logic [N-1:0] generalPin, // Pins
  input wire logic [2*N-1:0] pinEdgeSelect, // Selects
  input wire logic globalIrqMask, // Mask
  input wire logic group8Source, // Event
  input wire logic regRdStb, // Strobe
  input wire logic [7:0] regAddr, // Offset
  input wire logic [7:0] regRdData, // Data
  input wire logic regRdValid, // Valid
  input wire logic [N-1:0] pinEdgeFlag, // Flags
  input wire logic group8Pending, // Summary
  input wire logic interruptOut_n // Irq pin
);
  logic [N-1:0] selOn;
  logic [N-1:0] holdMask;
  logic rdEdge;
  logic rdSum;
  // Live selects and decoded reads
  always_comb begin
    for (int i = 0; i < N; i++) selOn[i] = |pinEdgeSelect[2*i +: 2];
  end
  assign holdMask = pinEdgeFlag & selOn;
  assign rdEdge = regRdStb && (regAddr == gefl_pkg::ADDR_EDGE_FLAGS);
  assign rdSum = regRdStb && (regAddr == gefl_pkg::ADDR_SUMMARY);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_RSVD: assert property (rdSum |=> regRdData[7:1] == 7'h00)
    else $error("reserved summary bits set");
  AST_SUM_SET: assert property (group8Source |=> group8Pending)
    else $error("summary flag missed");
  AST_SUM_CLR: assert property (rdSum && !group8Source |=> !group8Pending)
    else $error("summary flag not cleared");
  AST_RD_DATA: assert property (rdEdge |=> regRdValid && regRdData == $past(holdMask))
    else $error("edge flag read data wrong");
  AST_HOLD: assert property (!rdEdge |=> ($past(holdMask) & ~pinEdgeFlag) == 8'h00)
    else $error("edge flag dropped");
  AST_RD_CLR: assert property ($stable(generalPin) [*6] ##0 rdEdge |=> pinEdgeFlag == 8'h00)
    else $error("edge flags not cleared");
  AST_SEL_OFF: assert property (1 |=> (pinEdgeFlag & ~$past(selOn)) == 8'h00)
    else $error("masked pin flag set");
  AST_MASK: assert property (globalIrqMask ##1 globalIrqMask |-> interruptOut_n)
    else $error("masked interrupt pin low");
  AST_IRQ: assert property (!globalIrqMask ##1 !globalIrqMask
    |-> interruptOut_n == !((|pinEdgeFlag) || group8Pending))
    else $error("interrupt pin wrong");
endmodule : gefl_flags_asserts
bind gefl_irq_flags gefl_flags_asserts #(.N(N)) gefl_flags_asserts_inst (.clk_sys, .rst_n,
  .generalPin, .pinEdgeSelect, .globalIrqMask, .group8Source, .regRdStb, .regAddr,
  .regRdData, .regRdValid, .pinEdgeFlag, .group8Pending, .interruptOut_n);

// [gefl_host_model.sv]
/* Host side model that reads flag registers.
   Assumes one-cycle strobes and a valid pulse a cycle later. */
`timescale 1ns/100ps
module gefl_host_model (
  input wire logic clk_sys, // Clock
  output logic regRdStb, // Strobe
  output logic [7:0] regAddr, // Offset
  input wire logic [7:0] regRdData, // Data
  input wire logic regRdValid // Valid
);
  // Idle host; it never writes, so reserved bits stay zero
  initial begin
    regRdStb = 1'b0;
    regAddr = 8'h00;
  end
  // One read; address is scrambled once released
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    regRdStb = 1'b1;
    regAddr = a;
    @(negedge clk_sys);
    regRdStb = 1'b0;
    regAddr = ~a;
    d = regRdValid ? regRdData : 8'hXX;
  endtask : rd
endmodule : gefl_host_model

// [gefl_irq_flags.sv]
/*
  Second-level interrupt flags: eight sticky pin edge flags and the
  group-8 summary flag, both cleared on read, plus the interrupt pin.
  Assumes a register port on clk_sys that gives one-cycle read strobes,
  and edge-select and global mask levels from the same clock domain.
  Assumes the host never writes these registers; reserved summary bits
  are driven as zero although their read value carries no meaning.
  Assumes group8Source is a clean pulse or level from logic on clk_sys,
  so it passes no synchroniser.
  Assumes N is at most eight; flags above bit seven are not readable.
  The interrupt pin idles high and is released during reset.
*/
`timescale 1ns/100ps
module gefl_irq_flags #(
  parameter int N = gefl_pkg::NUM_PINS
) (
  input wire logic clk_sys,               // System clock, 40 MHz
  input wire logic rst_n,                 // Async reset, active low
  input wire logic [N-1:0] generalPin,    // Asynchronous general pins
  input wire logic [2*N-1:0] pinEdgeSelect, // Two bits per pin, held elsewhere
  input wire logic globalIrqMask,         // 1 masks the interrupt pin
  input wire logic group8Source,          // Group-8 event, same clock
  input wire logic regRdStb,              // One-cycle read strobe
  input wire logic [7:0] regAddr,         // Register offset
  output logic [7:0] regRdData,           // Read data, registered
  output logic regRdValid,                // Read data valid pulse
  output logic [N-1:0] pinEdgeFlag,       // Edge flag view
  output logic group8Pending,             // Summary flag view
  output logic interruptOut_n             // Interrupt pin, active low
);

  // Edge pulses from the detector, one lane per pin
  gefl_edge_if #(.N(N)) edgeBus ();

  // Pins pass the three-stage synchroniser before any edge is judged,
  // so a slow pin edge is counted once, after it has settled
  gefl_edge_det #(.N(N)) uEdgeDet (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(generalPin),
    .edges(edgeBus.src)
  );

  // Flag state and its next values
  logic [N-1:0] edgeFlags_r, edgeFlags_nxt;
  logic summaryPend_r, summaryPend_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  logic rdValid_r, rdValid_nxt;
  logic irqOutN_r, irqOutN_nxt;

  // Per-pin qualification and read decode
  logic [N-1:0] qualEdge;
  logic [N-1:0] pinEnabled;
  logic [7:0] edgeImage;
  logic rdEdge, rdSummary;
  logic anyPend;

  // Per-pin qualification against its edge-select code
  generate
    for (genvar g = 0; g < N; g++) begin : gQual
      gefl_pkg::gefl_edge_sel_t sel;
      assign sel = gefl_pkg::gefl_edge_sel_t'(pinEdgeSelect[2*g +: 2]);
      assign pinEnabled[g] = (sel != gefl_pkg::GEFL_SEL_OFF);
      logic hit;
      // Code 00 never qualifies, so a masked pin cannot set its flag
      always_comb begin
        case (sel)
          gefl_pkg::GEFL_SEL_RISE: hit = edgeBus.riseSeen[g];
          gefl_pkg::GEFL_SEL_FALL: hit = edgeBus.fallSeen[g];
          gefl_pkg::GEFL_SEL_BOTH: hit = edgeBus.riseSeen[g] | edgeBus.fallSeen[g];
          default: hit = 1'b0;
        endcase
      end
      assign qualEdge[g] = hit;
    end
  endgenerate

  // Eight-bit read image; masked pins and bits past N read zero.
  // Limitation: flags above bit seven never reach the read port.
  generate
    for (genvar b = 0; b < 8; b++) begin : gImage
      if (b < N) begin : gPin
        assign edgeImage[b] = edgeFlags_r[b] & pinEnabled[b];
      end else begin : gPad
        assign edgeImage[b] = 1'b0;
      end
    end
  endgenerate

  // Address decode of the read strobe; only one offset can match,
  // the chain just keeps the priority explicit
  always_comb begin
    rdEdge = 1'b0;
    rdSummary = 1'b0;
    if (regRdStb && (regAddr == gefl_pkg::ADDR_EDGE_FLAGS)) begin
      rdEdge = 1'b1;
    end else if (regRdStb && (regAddr == gefl_pkg::ADDR_SUMMARY)) begin
      rdSummary = 1'b1;
    end
  end

  // Edge flags: sticky, read-clear, set wins over a same-cycle read,
  // so an edge in the read cycle shows at the next read, never lost
  always_comb begin
    edgeFlags_nxt = edgeFlags_r;
    if (rdEdge) begin
      edgeFlags_nxt = '0;
    end
    edgeFlags_nxt = edgeFlags_nxt | qualEdge;
    // Masking forces zero even on a flag set before the mask
    edgeFlags_nxt = edgeFlags_nxt & pinEnabled;
  end

  // Edge flag register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      edgeFlags_r <= gefl_pkg::EDGE_FLAGS_RST;
    end else begin
      edgeFlags_r <= edgeFlags_nxt;
    end
  end

  // Summary flag: set by group-8 event, cleared by reading its register;
  // an event beats a same-cycle read, which then reports the older state
  always_comb begin
    summaryPend_nxt = summaryPend_r;
    if (rdSummary) begin
      summaryPend_nxt = 1'b0;
    end
    if (group8Source) begin
      summaryPend_nxt = 1'b1;
    end
  end

  // Summary flag register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      summaryPend_r <= gefl_pkg::SUMMARY_PEND_RST;
    end else begin
      summaryPend_r <= summaryPend_nxt;
    end
  end

  // Read data: value before the clear; unmapped offsets read zero
  // with no error, since the port has no way to signal one
  always_comb begin
    rdData_nxt = rdData_r;
    if (rdEdge) begin
      rdData_nxt = edgeImage;
    end else if (rdSummary) begin
      rdData_nxt = gefl_pkg::RSVD_RD;
      rdData_nxt[gefl_pkg::SUMMARY_PEND_BIT] = summaryPend_r;
    end else if (regRdStb) begin
      rdData_nxt = gefl_pkg::UNMAPPED_RD;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r <= gefl_pkg::RD_DATA_RST;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  // Valid pulse: one cycle after every strobe, mapped or not
  always_comb begin
    rdValid_nxt = regRdStb;
  end

  // Valid flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= rdValid_nxt;
    end
  end

  // Unmasked demand; masked pins are already zero in the flags
  always_comb begin
    anyPend = (|edgeFlags_nxt) || summaryPend_nxt;
  end

  // Interrupt pin follows next flag state, so it tracks flags exactly;
  // the price is a longer path from the pins into the pin flop
  always_comb begin
    irqOutN_nxt = 1'b1;
    if (!globalIrqMask && anyPend) begin
      irqOutN_nxt = 1'b0;
    end
    if (globalIrqMask) begin
      irqOutN_nxt = 1'b1;
    end
  end

  // Pin flop resets to the released level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irqOutN_r <= 1'b1;
    end else begin
      irqOutN_r <= irqOutN_nxt;
    end
  end

  // Outputs straight from their flops
  assign regRdData = rdData_r;
  assign regRdValid = rdValid_r;
  assign pinEdgeFlag = edgeFlags_r;
  assign group8Pending = summaryPend_r;
  assign interruptOut_n = irqOutN_r;

endmodule : gefl_irq_flags

// [gefl_irq_flags_tb.sv]
/* Self-checking bench for the edge flag block.
   Assumes the host model and the bound checker. */
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h", $time, a); end end
module gefl_irq_flags_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] generalPin = 8'h00;
  logic [15:0] pinEdgeSelect = 16'h5539;
  logic globalIrqMask = 1'b0;
  logic group8Source = 1'b0;
  logic regRdStb, regRdValid, group8Pending, interruptOut_n;
  logic [7:0] regAddr, regRdData, pinEdgeFlag, d;
  int err_total = 0;
  int n_tests = 0;
  gefl_irq_flags gefl_irq_flags_inst (.clk_sys, .rst_n, .generalPin, .pinEdgeSelect,
    .globalIrqMask, .group8Source, .regRdStb, .regAddr, .regRdData, .regRdValid,
    .pinEdgeFlag, .group8Pending, .interruptOut_n);
  gefl_host_model gefl_host_model_inst (.clk_sys, .regRdStb, .regAddr, .regRdData,
    .regRdValid);
  // 25 ns clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : w
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    gefl_host_model_inst.rd(a, d);
    `CHK(d, e)
  endtask : rdx
  task automatic summarize;
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // Hang guard, well past the roughly 80 cycles used
  initial begin
    repeat (3000) @(posedge clk_sys);
    err_total++;
    summarize();
  end
  // Pin0 rise, pin1 fall, pin2 both, pin3 off, others rise
  initial begin
    w(10);
    rst_n = 1'b1;
    rdx(8'h06, 8'h00);
    `CHK(interruptOut_n, 1'b1)
    generalPin = 8'hFF;
    w(8);
    `CHK(interruptOut_n, 1'b0)
    rdx(8'h06, 8'hF5);
    rdx(8'h06, 8'h00);
    `CHK(interruptOut_n, 1'b1)
    generalPin = 8'h00;
    w(8);
    rdx(8'h06, 8'h06);
    globalIrqMask = 1'b1;
    group8Source = 1'b1;
    w(1);
    group8Source = 1'b0;
    w(2);
    `CHK(interruptOut_n, 1'b1)
    `CHK(group8Pending, 1'b1)
    rdx(8'h05, 8'h01);
    rdx(8'h05, 8'h00);
    rdx(8'h10, 8'h00);
    globalIrqMask = 1'b0;
    // Event held across a read: set must win over the clear
    group8Source = 1'b1;
    rdx(8'h05, 8'h01);
    group8Source = 1'b0;
    `CHK(interruptOut_n, 1'b0)
    `CHK(group8Pending, 1'b1)
    rdx(8'h05, 8'h01);
    rdx(8'h05, 8'h00);
    `CHK(interruptOut_n, 1'b1)
    generalPin = 8'h01;
    w(8);
    `CHK(pinEdgeFlag, 8'h01)
    pinEdgeSelect = 16'h5538;
    w(2);
    `CHK(pinEdgeFlag, 8'h00)
    // Pins high through a mid-run reset must not look like an edge
    generalPin = 8'hFF;
    w(8);
    `CHK(pinEdgeFlag, 8'hF4)
    `CHK(interruptOut_n, 1'b0)
    rst_n = 1'b0;
    w(2);
    `CHK(pinEdgeFlag, 8'h00)
    `CHK(interruptOut_n, 1'b1)
    rst_n = 1'b1;
    w(10);
    `CHK(pinEdgeFlag, 8'h00)
    `CHK(interruptOut_n, 1'b1)
    rdx(8'h06, 8'h00);
    summarize();
  end
endmodule : gefl_irq_flags_tb

// [gefl_pkg.sv]
/*
  Constants for the second-level edge interrupt flag block: register
  offsets, field positions, reset values and edge-select codes.
  Assumes the register port of the device decodes eight-bit offsets.
*/
package gefl_pkg;

  // Register offsets on the device register port
  localparam logic [7:0] ADDR_SUMMARY = 8'h05;
  localparam logic [7:0] ADDR_EDGE_FLAGS = 8'h06;

  // Field layout
  localparam int NUM_PINS = 8;
  localparam int SUMMARY_PEND_BIT = 0;
  localparam int SEL_WIDTH = 2;

  // Reset values
  localparam logic [7:0] EDGE_FLAGS_RST = 8'h00;
  localparam logic SUMMARY_PEND_RST = 1'b0;
  localparam logic [7:0] RD_DATA_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  localparam logic [7:0] RSVD_RD = 8'h00;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

  // Per-pin edge selection; code 0 masks the pin
  typedef enum logic [1:0] {
    GEFL_SEL_OFF = 2'b00,
    GEFL_SEL_RISE = 2'b01,
    GEFL_SEL_FALL = 2'b10,
    GEFL_SEL_BOTH = 2'b11
  } gefl_edge_sel_t;

endpackage : gefl_pkg
